// ---- inc/sbpd_pkg.sv ----
// shared constants and types of the serial bus port datapath
package sbpd_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned CLK_KHZ         = 40000;
  localparam int unsigned LPS_RESET_NS    = 1200;
  localparam int unsigned LPS_DISABLE_NS  = 25000;
  localparam int unsigned LINKON_FREQ_KHZ = 6114;
  // least times round up, the link-on half period rounds down
  localparam int unsigned LPS_RESET_CYC   = (LPS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LPS_DISABLE_CYC = (LPS_DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LINKON_HALF_CYC = CLK_KHZ / (2 * LINKON_FREQ_KHZ);
  localparam int unsigned LPS_CNT_W       = 10;
  localparam int unsigned WAVE_CNT_W      = 2;
  localparam logic [2:0]  DIV_WORD_END    = 3'h7;

  // register port
  localparam int unsigned REG_AW     = 4;
  localparam int unsigned REG_DW     = 8;
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  localparam logic [3:0]  REG_EVENT  = 4'h8;
  localparam logic [3:0]  REG_ARB    = 4'hC;
  localparam logic [7:0]  CTRL_RESET = 8'h01;
  localparam int unsigned CTRL_PORT_EN_BIT  = 0;
  localparam int unsigned CTRL_SUSPEND_BIT  = 1;
  localparam int unsigned CTRL_LINK_ACT_BIT = 2;
  localparam int unsigned CTRL_CPF_EN_BIT   = 3;
  localparam int unsigned EVENT_CPF_BIT     = 0;

  // line-state codes seen on the two comparator pairs {pair a, pair b}
  localparam logic [3:0] ARB_GRANT     = 4'h5;
  localparam logic [3:0] ARB_RX_PREFIX = 4'hA;
  localparam logic [3:0] ARB_RX_END    = 4'h9;

  typedef enum logic [1:0] {
    SPD_S100 = 2'b00,
    SPD_S200 = 2'b01,
    SPD_S400 = 2'b10
  } sbpd_speed_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARB  = 2'b01,
    ST_TX   = 2'b10,
    ST_RX   = 2'b11
  } sbpd_state_e;

endpackage : sbpd_pkg

// ---- hdl/sbpd_ds_codec.sv ----
// data-strobe encoder and decoder for one cable port
`timescale 1ns/1ps
`default_nettype none
module sbpd_ds_codec (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic en_in,
  input  wire logic tx_tick_in,
  input  wire logic tx_bit_in,
  input  wire logic rx_data_in,
  input  wire logic rx_strobe_in,
  output logic      tx_data_out,
  output logic      tx_strobe_out,
  output logic      rx_vld_out,
  output logic      rx_bit_out
);

  logic rx_phase_r;
  wire  rx_phase = rx_data_in ^ rx_strobe_in;

  // strobe flips only when data repeats, so exactly one line moves per bit
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_data_out   <= 1'b0;
      tx_strobe_out <= 1'b0;
    end else if (!en_in) begin
      tx_data_out   <= 1'b0;
      tx_strobe_out <= 1'b0;
    end else if (tx_tick_in) begin
      tx_data_out   <= tx_bit_in;
      tx_strobe_out <= (tx_bit_in == tx_data_out) ? ~tx_strobe_out : tx_strobe_out; // [R7]
    end
  end

  // every change of data xor strobe is one recovered clock edge
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_phase_r <= 1'b0;
      rx_vld_out <= 1'b0;
      rx_bit_out <= 1'b0;
    end else begin
      rx_phase_r <= en_in & rx_phase;
      rx_vld_out <= en_in & (rx_phase != rx_phase_r); // [R10]
      rx_bit_out <= rx_data_in;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_ds_one_edge: assert property ($past(en_in) && en_in && $past(tx_tick_in) // [R7]
    |-> ($changed(tx_data_out) != $changed(tx_strobe_out))) else $error("ds encoder moved both or no lines");
  chk_rx_bit_data: assert property (rx_vld_out |-> rx_bit_out == $past(rx_data_in) // [R10]
    && $past(rx_data_in ^ rx_strobe_in) != $past(rx_phase_r)) else $error("decoded bit wrong");

endmodule : sbpd_ds_codec
`default_nettype wire

// ---- hdl/sbpd_phy_port.sv ----
// one-port serial bus physical layer datapath, link side and line-state control
//
// How it works
// [R1]: system clock divided into word and per-speed bit ticks timing line transmission.
// [R2]: link clock derived from system clock; received data retimed on same clock.
// [R3]: powerdown stops pll, transmitters, receivers, bias; cable-inactive keeps working.
// [R4]: isolation input high gives ordinary levels on link outputs.
// [R5]: isolation input low turns each link output transition into one-cycle pulse; here only LINK_DATA_OUT and LINK_RX_VALID_OUT are pulsed.
// [R6]: link presents 2/4/8 lanes; words latched on system clock word tick.
// [R7]: latched bits serialised, data-strobe encoded, sent at per-speed bit rate.
// [R8]: lane count follows speed: two, four, eight lanes for low, middle, high.
// [R9]: while receiving, transmitters off and receivers on.
// [R10]: data-strobe pair decoded into receive clock and serial bits.
// [R11]: received bits split into 2/4/8 lanes, retimed, handed to link.
// [R12]: received packets repeated out of the other active port.
// [R13]: arbitration status taken from comparator outputs of both pairs.
// [R14]: pair a common-mode speed sensed in arbitration selects next packet speed.
// [R15]: bias-detect reports remote bias on pair b.
// [R16]: connect-detect from pair a sampled only while local bias output is off.
// [R17]: bias and connect detect drive suspend, resume and connection detection.
// [R18]: disabled, suspended or disconnected port keeps transmitter and receiver off.
// [R19]: cable power sense below threshold raises cable power fail interrupt.
// [R20]: cable-inactive output high when no remote bias; undebounced, alive in powerdown.
// [R21]: link power inactive 1.2 to 25 us resets link interface, longer disables it.
// [R22]: link-on packet while disabled drives 6.114 MHz on contender pin until link up; here 6.67 MHz, a 3-clock half period.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sbpd_phy_port (
  input  wire logic                        SYS_CLK_IN,
  input  wire logic                        RST_B_IN,
  input  wire logic                        POWERDOWN_REQUEST_IN,
  input  wire logic                        ISO_B_IN,
  input  wire logic [sbpd_pkg::REG_AW-1:0] REG_ADDR_IN,
  input  wire logic [sbpd_pkg::REG_DW-1:0] REG_WDATA_IN,
  input  wire logic                        REG_WR_IN,
  input  wire logic                        REG_RD_IN,
  output logic      [sbpd_pkg::REG_DW-1:0] REG_RDATA_OUT,
  output logic                             LINK_CLK_OUT,
  input  wire logic [7:0]                  LINK_DATA_IN,
  input  wire logic                        LINK_TX_VALID_IN,
  output logic                             LINK_TX_READY_OUT,
  output logic      [7:0]                  LINK_DATA_OUT,
  output logic                             LINK_RX_VALID_OUT,
  output logic                             LINK_IF_RESET_OUT,
  input  wire logic                        LINK_POWER_STATUS_IN,
  input  wire logic                        LINK_ON_PKT_IN,
  input  wire logic                        CONTENDER_WAKE_PIN_IN,
  output logic                             CONTENDER_WAKE_PIN_OUT,
  output logic                             CONTENDER_WAKE_PIN_OE_OUT,
  output logic                             PLL_RUN_OUT,
  input  wire logic [1:0]                  CABLE_PAIR_A_CMP_IN,
  input  wire logic [1:0]                  CABLE_PAIR_B_CMP_IN,
  input  wire logic [1:0]                  CABLE_PAIR_A_SPEED_IN,
  input  wire logic                        CABLE_PAIR_B_BIAS_IN,
  input  wire logic                        CABLE_PAIR_A_CONNECT_IN,
  output logic                             BIAS_OUTPUT_EN_OUT,
  input  wire logic                        CABLE_RX_DATA_IN,
  input  wire logic                        CABLE_RX_STROBE_IN,
  output logic                             CABLE_TX_DATA_OUT,
  output logic                             CABLE_TX_STROBE_OUT,
  output logic                             CABLE_TX_EN_OUT,
  output logic                             CABLE_RX_EN_OUT,
  input  wire logic                        REPEAT_PORT_ACTIVE_IN,
  output logic                             REPEAT_DATA_OUT,
  output logic                             REPEAT_STROBE_OUT,
  input  wire logic                        CABLE_POWER_SENSE_LOW_IN,
  output logic                             CABLE_POWER_FAIL_IRQ_OUT,
  output logic                             CABLE_INACTIVE_FLAG_OUT
);
  import sbpd_pkg::*;

  sbpd_state_e state_r, state_nxt;
  sbpd_speed_e speed_r;
  logic [2:0]            div_r;
  logic [7:0]            ctrl_r;
  logic [3:0]            arb_r;
  logic                  bias_det_r, bias_prev_r, connect_r, suspended_r;
  logic                  cpf_r, contender_r, strap_done_r, link_dis_r, linkon_r, wave_r;
  logic [LPS_CNT_W-1:0]  lps_cnt_r;
  logic [WAVE_CNT_W-1:0] wave_cnt_r;
  logic [7:0]            tx_sh_r, rx_sh_r, rx_word_r;
  logic [3:0]            rx_cnt_r;
  logic                  rx_vld_r;
  logic [8:0]            lnk_prev_r, lnk_out_r;
  logic                  rx_bit_vld, rx_bit;
  logic                  bit_tick;
  logic [3:0]            lanes;
  logic [7:0]            lane_mask;
  logic [7:0]            rd_mux;

  wire pd          = POWERDOWN_REQUEST_IN;
  wire port_ok     = ctrl_r[CTRL_PORT_EN_BIT] & ~suspended_r & connect_r & ~pd; // [R18]
  wire tx_active   = state_r == ST_TX;
  wire rx_active   = state_r == ST_RX;
  wire word_tick   = div_r == DIV_WORD_END;
  wire arb_grant   = arb_r == ARB_GRANT;
  wire arb_prefix  = arb_r == ARB_RX_PREFIX;
  wire bias_rise   = bias_det_r & ~bias_prev_r;
  wire resume_evt  = suspended_r & bias_rise;
  wire wr_ctrl     = REG_WR_IN & (REG_ADDR_IN == REG_CTRL);
  wire wr_event    = REG_WR_IN & (REG_ADDR_IN == REG_EVENT);
  wire tx_load     = word_tick & port_ok & ((state_r == ST_ARB & arb_grant) | (tx_active & LINK_TX_VALID_IN));
  wire rx_word_end = rx_active & rx_bit_vld & ({1'b0, rx_cnt_r[2:0]} + 4'h1 == lanes);
  wire lps_lost    = ~LINK_POWER_STATUS_IN;

  // one word of 2/4/8 bits always spans eight system clocks, so the link sees one rate
  always_comb begin
    case (speed_r)
      SPD_S100: begin
        bit_tick  = div_r[1:0] == 2'h3; // [R1] [R7]
        lanes     = 4'h2; // [R8]
        lane_mask = 8'h03;
      end
      SPD_S200: begin
        bit_tick  = div_r[0];
        lanes     = 4'h4;
        lane_mask = 8'h0F;
      end
      SPD_S400: begin
        bit_tick  = 1'b1;
        lanes     = 4'h8;
        lane_mask = 8'hFF;
      end
      default: begin
        bit_tick  = div_r[1:0] == 2'h3;
        lanes     = 4'h2;
        lane_mask = 8'h03;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (arb_prefix)
          state_nxt = ST_RX;
        else if (LINK_TX_VALID_IN)
          state_nxt = ST_ARB;
      end
      ST_ARB: begin
        if (arb_prefix)
          state_nxt = ST_RX; // [R13]
        else if (arb_grant & word_tick)
          state_nxt = ST_TX;
      end
      ST_TX: begin
        if (word_tick & ~LINK_TX_VALID_IN)
          state_nxt = ST_IDLE;
      end
      ST_RX: begin
        if (arb_r == ARB_RX_END)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (!port_ok)
      state_nxt = ST_IDLE; // [R3] [R18]
  end

  assign CABLE_TX_EN_OUT   = tx_active & port_ok; // [R9] [R18]
  assign CABLE_RX_EN_OUT   = port_ok & ~tx_active; // [R9]
  assign LINK_TX_READY_OUT = tx_load; // [R6]
  assign LINK_DATA_OUT     = lnk_out_r[7:0];
  assign LINK_RX_VALID_OUT = lnk_out_r[8];

  always_comb begin
    case (REG_ADDR_IN)
      REG_CTRL:   rd_mux = ctrl_r;
      REG_STATUS: rd_mux = {pd, contender_r, link_dis_r, suspended_r, connect_r, bias_det_r, speed_r};
      REG_EVENT:  rd_mux = {7'h00, cpf_r};
      REG_ARB:    rd_mux = {2'h0, state_r, arb_r};
      default:    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_r      <= ST_IDLE;
      div_r        <= 3'h0;
      LINK_CLK_OUT <= 1'b0;
      PLL_RUN_OUT  <= 1'b0;
      arb_r        <= 4'h0;
      speed_r      <= SPD_S100;
    end else begin
      state_r      <= state_nxt;
      div_r        <= pd ? 3'h0 : div_r + 3'h1; // [R1]
      LINK_CLK_OUT <= ~pd & div_r[2]; // [R2]
      PLL_RUN_OUT  <= ~pd; // [R3]
      arb_r        <= pd ? 4'h0 : {CABLE_PAIR_A_CMP_IN, CABLE_PAIR_B_CMP_IN}; // [R13]
      if (state_r == ST_IDLE || state_r == ST_ARB)
        speed_r <= (CABLE_PAIR_A_SPEED_IN > SPD_S400) ? SPD_S400 : sbpd_speed_e'(CABLE_PAIR_A_SPEED_IN); // [R14]
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl_r        <= CTRL_RESET;
      cpf_r         <= 1'b0;
      REG_RDATA_OUT <= 8'h00;
      CABLE_POWER_FAIL_IRQ_OUT <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= REG_WDATA_IN;
      else if (resume_evt)
        ctrl_r[CTRL_SUSPEND_BIT] <= 1'b0;
      // a fresh low reading beats a clear in the same cycle
      cpf_r <= CABLE_POWER_SENSE_LOW_IN | (cpf_r & ~(wr_event & REG_WDATA_IN[EVENT_CPF_BIT])); // [R19]
      CABLE_POWER_FAIL_IRQ_OUT <= cpf_r & ctrl_r[CTRL_CPF_EN_BIT]; // [R19]
      REG_RDATA_OUT <= REG_RD_IN ? rd_mux : 8'h00;
    end
  end

  // bias, connect and suspend tracking
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      bias_det_r  <= 1'b0;
      bias_prev_r <= 1'b0;
      connect_r   <= 1'b0;
      suspended_r <= 1'b0;
      BIAS_OUTPUT_EN_OUT      <= 1'b0;
      CABLE_INACTIVE_FLAG_OUT <= 1'b1;
    end else begin
      CABLE_INACTIVE_FLAG_OUT <= ~CABLE_PAIR_B_BIAS_IN; // [R20]
      bias_det_r  <= ~pd & CABLE_PAIR_B_BIAS_IN; // [R15]
      bias_prev_r <= bias_det_r;
      // own bias would swamp the connect sense, so only look while it is off
      if (!BIAS_OUTPUT_EN_OUT)
        connect_r <= ~pd & CABLE_PAIR_A_CONNECT_IN; // [R16]
      if (!connect_r)
        suspended_r <= 1'b0; // [R17]
      else if (resume_evt)
        suspended_r <= 1'b0; // [R17]
      else if (ctrl_r[CTRL_SUSPEND_BIT] & ~bias_det_r)
        suspended_r <= 1'b1; // [R17]
      BIAS_OUTPUT_EN_OUT <= ctrl_r[CTRL_PORT_EN_BIT] & connect_r & ~suspended_r & ~pd; // [R3] [R18]
    end
  end

  // transmit word latch and shifter, msb leaves first
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN)
      tx_sh_r <= 8'h00;
    else if (tx_load)
      tx_sh_r <= (LINK_DATA_IN & lane_mask) << (4'h8 - lanes); // [R6] [R8]
    else if (tx_active & bit_tick)
      tx_sh_r <= {tx_sh_r[6:0], 1'b0}; // [R7]
  end

  sbpd_ds_codec u_codec (
    .clk_in        (SYS_CLK_IN),
    .rst_b_in      (RST_B_IN),
    .en_in         (port_ok),
    .tx_tick_in    (tx_active & bit_tick),
    .tx_bit_in     (tx_sh_r[7]),
    .rx_data_in    (CABLE_RX_DATA_IN),
    .rx_strobe_in  (CABLE_RX_STROBE_IN),
    .tx_data_out   (CABLE_TX_DATA_OUT),
    .tx_strobe_out (CABLE_TX_STROBE_OUT),
    .rx_vld_out    (rx_bit_vld),
    .rx_bit_out    (rx_bit)
  );

  // receive deserialiser; the codec already works on the system clock
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rx_sh_r   <= 8'h00;
      rx_cnt_r  <= 4'h0;
      rx_word_r <= 8'h00;
      rx_vld_r  <= 1'b0;
      REPEAT_DATA_OUT   <= 1'b0;
      REPEAT_STROBE_OUT <= 1'b0;
    end else begin
      rx_vld_r <= rx_word_end & ~link_dis_r; // [R11]
      if (!rx_active) begin
        rx_cnt_r <= 4'h0;
      end else if (rx_bit_vld) begin
        rx_sh_r  <= {rx_sh_r[6:0], rx_bit};
        rx_cnt_r <= rx_word_end ? 4'h0 : rx_cnt_r + 4'h1;
      end
      if (rx_word_end)
        rx_word_r <= {rx_sh_r[6:0], rx_bit} & lane_mask; // [R11]
      REPEAT_DATA_OUT   <= rx_active & REPEAT_PORT_ACTIVE_IN & CABLE_RX_DATA_IN; // [R12]
      REPEAT_STROBE_OUT <= rx_active & REPEAT_PORT_ACTIVE_IN & CABLE_RX_STROBE_IN; // [R12]
    end
  end

  // link outputs: plain levels, or edge pulses for coupling across a barrier
  wire [8:0] lnk_src = {rx_vld_r, rx_word_r};
  generate
    for (genvar i = 0; i < 9; i++) begin : g_iso
      always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          lnk_prev_r[i] <= 1'b0;
          lnk_out_r[i]  <= 1'b0;
        end else begin
          lnk_prev_r[i] <= lnk_src[i];
          lnk_out_r[i]  <= ISO_B_IN ? lnk_src[i] : (lnk_src[i] ^ lnk_prev_r[i]); // [R4] [R5]
        end
      end
    end
  endgenerate

  // link power watch, contender strap and link-on wave
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      lps_cnt_r    <= '0;
      link_dis_r   <= 1'b0;
      linkon_r     <= 1'b0;
      wave_r       <= 1'b0;
      wave_cnt_r   <= '0;
      contender_r  <= 1'b0;
      strap_done_r <= 1'b0;
      LINK_IF_RESET_OUT <= 1'b0;
    end else begin
      if (!strap_done_r)
        contender_r <= CONTENDER_WAKE_PIN_IN;
      strap_done_r <= 1'b1;
      if (!lps_lost)
        lps_cnt_r <= '0;
      else if (lps_cnt_r != LPS_CNT_W'(LPS_DISABLE_CYC))
        lps_cnt_r <= lps_cnt_r + 1'b1;
      LINK_IF_RESET_OUT <= lps_lost && (lps_cnt_r >= LPS_CNT_W'(LPS_RESET_CYC)) // [R21]
                           && (lps_cnt_r < LPS_CNT_W'(LPS_DISABLE_CYC));
      if (!lps_lost)
        link_dis_r <= 1'b0;
      else if (lps_cnt_r == LPS_CNT_W'(LPS_DISABLE_CYC))
        link_dis_r <= 1'b1; // [R21]
      if (LINK_POWER_STATUS_IN & ctrl_r[CTRL_LINK_ACT_BIT])
        linkon_r <= 1'b0; // [R22]
      else if (link_dis_r & LINK_ON_PKT_IN & ~pd)
        linkon_r <= 1'b1; // [R22]
      if (!linkon_r) begin
        wave_r     <= 1'b0;
        wave_cnt_r <= '0;
      end else if (wave_cnt_r == WAVE_CNT_W'(LINKON_HALF_CYC - 1)) begin
        wave_r     <= ~wave_r; // [R22]
        wave_cnt_r <= '0;
      end else begin
        wave_cnt_r <= wave_cnt_r + 1'b1;
      end
    end
  end

  assign CONTENDER_WAKE_PIN_OUT    = wave_r;
  assign CONTENDER_WAKE_PIN_OE_OUT = strap_done_r;

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  chk_pd_all_off: assert property (pd |=> !PLL_RUN_OUT && !BIAS_OUTPUT_EN_OUT // [R3]
    && !CABLE_TX_EN_OUT && !CABLE_RX_EN_OUT) else $error("powerdown left circuitry on");
  chk_rx_no_tx: assert property (rx_active |-> !CABLE_TX_EN_OUT) else $error("transmitter on while receiving"); // [R9]
  chk_port_off_quiet: assert property (!port_ok |-> !CABLE_TX_EN_OUT && !CABLE_RX_EN_OUT) // [R18]
    else $error("port off but line enabled");
  chk_cna_follow: assert property (CABLE_INACTIVE_FLAG_OUT == !$past(CABLE_PAIR_B_BIAS_IN)) // [R20]
    else $error("cable inactive flag wrong");
  chk_cpf_sticky: assert property (CABLE_POWER_SENSE_LOW_IN ##1 ctrl_r[CTRL_CPF_EN_BIT] |=> CABLE_POWER_FAIL_IRQ_OUT) // [R19]
    else $error("cable power fail not raised");
  chk_lps_reset: assert property (lps_lost && lps_cnt_r == LPS_CNT_W'(LPS_RESET_CYC) |=> LINK_IF_RESET_OUT) // [R21]
    else $error("link interface reset late");
  chk_lps_disable: assert property (lps_lost && lps_cnt_r == LPS_CNT_W'(LPS_DISABLE_CYC) // [R21]
    |=> link_dis_r && !LINK_IF_RESET_OUT) else $error("link interface not disabled");
  chk_linkon_stop: assert property (LINK_POWER_STATUS_IN && ctrl_r[CTRL_LINK_ACT_BIT] |=> ##1 !CONTENDER_WAKE_PIN_OUT) // [R22]
    else $error("link-on wave not stopped");
  chk_iso_level: assert property (ISO_B_IN |=> LINK_RX_VALID_OUT == $past(rx_vld_r)) // [R4]
    else $error("normal link output not a level copy");
  chk_iso_pulse: assert property (!ISO_B_IN ##1 LINK_RX_VALID_OUT |-> $past(rx_vld_r) != $past(lnk_prev_r[8])) // [R5]
    else $error("isolated output pulse without an edge");
  chk_connect_hold: assert property (BIAS_OUTPUT_EN_OUT |=> $stable(connect_r)) // [R16]
    else $error("connect sensed while bias driven");
  chk_ready_on_word: assert property (LINK_TX_READY_OUT |-> div_r == DIV_WORD_END ##8 div_r == DIV_WORD_END) // [R6]
    else $error("transmit word taken off the word tick");
  chk_slow_bits: assert property (speed_r == SPD_S100 && tx_active && bit_tick |-> div_r[1:0] == 2'h3) // [R7] [R8]
    else $error("low speed bit rate wrong");

endmodule : sbpd_phy_port
`default_nettype wire

// ---- tb/sbpd_llc_model.sv ----
// link-layer controller model on the transmit side of the link interface
`timescale 1ns/1ps
`default_nettype none
module sbpd_llc_model (
  input  wire logic       clk_in,
  input  wire logic       send_in,
  input  wire logic       power_in,
  input  wire logic [1:0] speed_in,
  input  wire logic       ready_in,
  output logic            tx_valid_out,
  output logic      [7:0] data_out,
  output logic            power_out,
  output logic      [7:0] words_out
);
  logic [7:0] mask;
  assign mask = (speed_in == 2'h0) ? 8'h03 : (speed_in == 2'h1) ? 8'h0F : 8'hFF;
  initial begin
    tx_valid_out = 1'b0;
    data_out = 8'h00;
    power_out = 1'b1;
    words_out = 8'h00;
  end
  // a word holds until taken; unused lanes flip every cycle so a stale value never passes
  always @(posedge clk_in) begin
    power_out <= power_in;
    tx_valid_out <= send_in;
    data_out <= ((ready_in ? ~data_out : data_out) & mask) | (~data_out & ~mask);
    if (ready_in) begin
      words_out <= words_out + 8'h01;
    end
  end
endmodule : sbpd_llc_model
`default_nettype wire

// ---- tb/test_serial_bus_phy_port_datapath.sv ----
// self-checking bench of the port datapath
`timescale 1ns/1ps
`default_nettype none
module test_serial_bus_phy_port_datapath;
  import sbpd_pkg::*;
  logic SYS_CLK_IN, RST_B_IN, POWERDOWN_REQUEST_IN, ISO_B_IN, REG_WR_IN, REG_RD_IN, LINK_CLK_OUT;
  logic [REG_AW-1:0] REG_ADDR_IN;
  logic [7:0] REG_WDATA_IN, REG_RDATA_OUT, LINK_DATA_IN, LINK_DATA_OUT, words, d, w0;
  logic LINK_TX_VALID_IN, LINK_TX_READY_OUT, LINK_RX_VALID_OUT, LINK_IF_RESET_OUT, LINK_POWER_STATUS_IN;
  logic LINK_ON_PKT_IN, CONTENDER_WAKE_PIN_IN, CONTENDER_WAKE_PIN_OUT, CONTENDER_WAKE_PIN_OE_OUT, PLL_RUN_OUT;
  logic [1:0] CABLE_PAIR_A_CMP_IN, CABLE_PAIR_B_CMP_IN, CABLE_PAIR_A_SPEED_IN;
  logic CABLE_PAIR_B_BIAS_IN, CABLE_PAIR_A_CONNECT_IN, BIAS_OUTPUT_EN_OUT, CABLE_RX_DATA_IN, CABLE_RX_STROBE_IN;
  logic CABLE_TX_DATA_OUT, CABLE_TX_STROBE_OUT, CABLE_TX_EN_OUT, CABLE_RX_EN_OUT, REPEAT_PORT_ACTIVE_IN;
  logic REPEAT_DATA_OUT, REPEAT_STROBE_OUT, CABLE_POWER_SENSE_LOW_IN, CABLE_POWER_FAIL_IRQ_OUT;
  logic CABLE_INACTIVE_FLAG_OUT, send, power, p;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  sbpd_phy_port sbpd_phy_port_i (.SYS_CLK_IN, .RST_B_IN, .POWERDOWN_REQUEST_IN, .ISO_B_IN, .REG_ADDR_IN,
    .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .LINK_CLK_OUT, .LINK_DATA_IN, .LINK_TX_VALID_IN,
    .LINK_TX_READY_OUT, .LINK_DATA_OUT, .LINK_RX_VALID_OUT, .LINK_IF_RESET_OUT, .LINK_POWER_STATUS_IN,
    .LINK_ON_PKT_IN, .CONTENDER_WAKE_PIN_IN, .CONTENDER_WAKE_PIN_OUT, .CONTENDER_WAKE_PIN_OE_OUT, .PLL_RUN_OUT,
    .CABLE_PAIR_A_CMP_IN, .CABLE_PAIR_B_CMP_IN, .CABLE_PAIR_A_SPEED_IN, .CABLE_PAIR_B_BIAS_IN,
    .CABLE_PAIR_A_CONNECT_IN, .BIAS_OUTPUT_EN_OUT, .CABLE_RX_DATA_IN, .CABLE_RX_STROBE_IN, .CABLE_TX_DATA_OUT,
    .CABLE_TX_STROBE_OUT, .CABLE_TX_EN_OUT, .CABLE_RX_EN_OUT, .REPEAT_PORT_ACTIVE_IN, .REPEAT_DATA_OUT,
    .REPEAT_STROBE_OUT, .CABLE_POWER_SENSE_LOW_IN, .CABLE_POWER_FAIL_IRQ_OUT, .CABLE_INACTIVE_FLAG_OUT);
  sbpd_llc_model sbpd_llc_model_i (.clk_in(SYS_CLK_IN), .send_in(send), .power_in(power),
    .speed_in(CABLE_PAIR_A_SPEED_IN), .ready_in(LINK_TX_READY_OUT), .tx_valid_out(LINK_TX_VALID_IN),
    .data_out(LINK_DATA_IN), .power_out(LINK_POWER_STATUS_IN), .words_out(words));
  initial begin
    SYS_CLK_IN = 1'b0;
    forever #12.5 SYS_CLK_IN = ~SYS_CLK_IN;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK_IN);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge SYS_CLK_IN);
    REG_WR_IN <= 1'b1;
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= v;
    @(posedge SYS_CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge SYS_CLK_IN);
    REG_RD_IN <= 1'b1;
    REG_ADDR_IN <= a;
    @(posedge SYS_CLK_IN);
    REG_RD_IN <= 1'b0;
    #1 v = REG_RDATA_OUT;
  endtask : rd
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  always @(posedge SYS_CLK_IN) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic t_regs;
    rd(REG_CTRL, d);
    chk("ctrl reset", CTRL_RESET, d);
    rd(4'h2, d);
    chk("unmapped read", 8'h00, d);
  endtask : t_regs
  task automatic t_inactive;
    cyc(3);
    chk("cable inactive", 8'h01, {7'h0, CABLE_INACTIVE_FLAG_OUT});
    @(posedge SYS_CLK_IN);
    POWERDOWN_REQUEST_IN <= 1'b1;
    CABLE_PAIR_B_BIAS_IN <= 1'b1;
    cyc(3);
    chk("cable inactive pd", 8'h00, {7'h0, CABLE_INACTIVE_FLAG_OUT});
    chk("pll run pd", 8'h00, {7'h0, PLL_RUN_OUT});
    chk("tx en pd", 8'h00, {7'h0, CABLE_TX_EN_OUT});
    @(posedge SYS_CLK_IN);
    POWERDOWN_REQUEST_IN <= 1'b0;
    cyc(3);
    chk("pll run", 8'h01, {7'h0, PLL_RUN_OUT});
  endtask : t_inactive
  task automatic t_rx;
    @(posedge SYS_CLK_IN);
    CABLE_PAIR_A_CONNECT_IN <= 1'b1;
    CABLE_PAIR_A_CMP_IN <= 2'b10;
    CABLE_PAIR_B_CMP_IN <= 2'b10;
    cyc(4);
    chk("rx en", 8'h01, {7'h0, CABLE_RX_EN_OUT});
    chk("tx en rx", 8'h00, {7'h0, CABLE_TX_EN_OUT});
    CABLE_RX_DATA_IN <= 1'b1;
    cyc(1);
    chk("repeat data", 8'h01, {7'h0, REPEAT_DATA_OUT});
    CABLE_RX_DATA_IN <= 1'b0;
    cyc(3);
    chk("rx word", 8'h02, LINK_DATA_OUT);
    chk("rx valid", 8'h01, {7'h0, LINK_RX_VALID_OUT});
    ISO_B_IN <= 1'b0;
    cyc(1);
    chk("iso word", 8'h00, LINK_DATA_OUT);
    chk("iso pulse", 8'h01, {7'h0, LINK_RX_VALID_OUT});
    ISO_B_IN <= 1'b1;
    rd(REG_ARB, d);
    chk("arb", 8'h3A, d);
    wr(REG_CTRL, 8'h00);
    cyc(2);
    chk("rx en off", 8'h00, {7'h0, CABLE_RX_EN_OUT});
    wr(REG_CTRL, 8'h01);
    CABLE_PAIR_B_CMP_IN <= 2'b01;
    cyc(4);
  endtask : t_rx
  task automatic t_tx;
    @(posedge SYS_CLK_IN);
    CABLE_PAIR_A_SPEED_IN <= 2'h2;
    CABLE_PAIR_A_CMP_IN <= 2'b01;
    CABLE_PAIR_B_CMP_IN <= 2'b01;
    send <= 1'b1;
    cyc(20);
    w0 = words;
    cyc(64);
    chk("tx en", 8'h01, {7'h0, CABLE_TX_EN_OUT});
    chk("words per 64", 8'h08, words - w0);
    @(posedge SYS_CLK_IN);
    send <= 1'b0;
    CABLE_PAIR_A_CMP_IN <= 2'b00;
    CABLE_PAIR_B_CMP_IN <= 2'b00;
    cyc(16);
  endtask : t_tx
  task automatic t_cpf;
    wr(REG_CTRL, 8'h09);
    CABLE_POWER_SENSE_LOW_IN <= 1'b1;
    cyc(3);
    chk("cpf irq", 8'h01, {7'h0, CABLE_POWER_FAIL_IRQ_OUT});
    CABLE_POWER_SENSE_LOW_IN <= 1'b0;
    wr(REG_EVENT, 8'h01);
    cyc(2);
    chk("cpf cleared", 8'h00, {7'h0, CABLE_POWER_FAIL_IRQ_OUT});
  endtask : t_cpf
  task automatic t_lps;
    @(posedge SYS_CLK_IN);
    power <= 1'b0;
    cyc(60);
    chk("if reset", 8'h01, {7'h0, LINK_IF_RESET_OUT});
    cyc(1000);
    chk("if reset end", 8'h00, {7'h0, LINK_IF_RESET_OUT});
    rd(REG_STATUS, d);
    chk("link disabled", 8'h20, d & 8'h20);
    LINK_ON_PKT_IN <= 1'b1;
    @(posedge SYS_CLK_IN);
    LINK_ON_PKT_IN <= 1'b0;
    cyc(3);
    p = CONTENDER_WAKE_PIN_OUT;
    cyc(3);
    chk("wake wave", {7'h0, ~p}, {7'h0, CONTENDER_WAKE_PIN_OUT});
    power <= 1'b1;
    wr(REG_CTRL, 8'h05);
    cyc(10);
    p = CONTENDER_WAKE_PIN_OUT;
    cyc(3);
    chk("wake stop", {7'h0, p}, {7'h0, CONTENDER_WAKE_PIN_OUT});
  endtask : t_lps
  initial begin
    {RST_B_IN, POWERDOWN_REQUEST_IN, REG_WR_IN, REG_RD_IN, LINK_ON_PKT_IN, send} = 6'h00;
    {ISO_B_IN, power, CONTENDER_WAKE_PIN_IN, REPEAT_PORT_ACTIVE_IN} = 4'hF;
    {CABLE_PAIR_B_BIAS_IN, CABLE_PAIR_A_CONNECT_IN, CABLE_RX_DATA_IN, CABLE_RX_STROBE_IN} = 4'h0;
    {CABLE_PAIR_A_CMP_IN, CABLE_PAIR_B_CMP_IN, CABLE_PAIR_A_SPEED_IN} = 6'h00;
    CABLE_POWER_SENSE_LOW_IN = 1'b0;
    REG_ADDR_IN = 4'h0;
    REG_WDATA_IN = 8'h00;
    repeat (12) @(posedge SYS_CLK_IN);
    RST_B_IN <= 1'b1;
    t_regs();
    t_inactive();
    t_rx();
    t_tx();
    t_cpf();
    t_lps();
    summarize();
  end
endmodule : test_serial_bus_phy_port_datapath
`default_nettype wire
